// >>> rtl/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

	// Source count and field widths.
	localparam int NUM_SRC = 86;
	localparam int VNUM_W  = 7;
	localparam int PRIO_W  = 2;
	localparam int LEVEL_W = 2;
	localparam int ADDR_W  = 21;
	localparam int FVL_W   = 16;
	localparam int FVH_W   = ADDR_W - FVL_W;
	localparam int VBASE_W = ADDR_W - VNUM_W;

	// Values after reset, and the last source number.
	localparam logic [PRIO_W-1:0]  PRIO_DISABLED = 2'h0;
	localparam logic [ADDR_W-1:0]  INIT_ADDR     = 21'h000000;
	localparam logic [VNUM_W-1:0]  VNUM_RESET    = 7'h00;
	localparam logic [VNUM_W-1:0]  LAST_SRC      = 7'h55;

	// Current level codes; a code's value is also the least admitted level.
	localparam logic [1:0] CODE_NONE = 2'h0;
	localparam logic [1:0] CODE_L0   = 2'h1;
	localparam logic [1:0] CODE_L1   = 2'h2;
	localparam logic [1:0] CODE_L23  = 2'h3;

	// The level that a fast interrupt must have.
	localparam logic [LEVEL_W-1:0] FAST_LEVEL = 2'h2;

	// Power modes reported by the system integration unit.
	typedef enum logic [1:0]
	{
		MODE_RUN  = 2'b00,
		MODE_WAIT = 2'b01,
		MODE_STOP = 2'b10
	} power_mode_t;

	// One fast interrupt slot: match number and full handler address.
	typedef struct packed
	{
		logic [VNUM_W-1:0] match;
		logic [FVH_W-1:0]  high;
		logic [FVL_W-1:0]  low;
	} fast_cfg_t;

	// The request presented to the core.
	typedef struct packed
	{
		logic               valid;
		logic               fast;
		logic [LEVEL_W-1:0] level;
		logic [VNUM_W-1:0]  num;
		logic [ADDR_W-1:0]  addr;
	} core_req_t;

	// Priority field write from software.
	typedef struct packed
	{
		logic              en;
		logic [VNUM_W-1:0] index;
		logic [PRIO_W-1:0] field;
	} prio_wr_t;

endpackage

// >>> rtl/priority_level_regs.sv
`timescale 1ns/100ps

// Holds the two-bit priority field of every source. All fields are flops
// because the arbiter must see them all at once; a single-field read port
// is registered for software readback.
module priority_level_regs
	import irq_ctrl_pkg::*;
#(
	parameter logic [NUM_SRC-1:0]        FIXED_MASK   = '0,
	parameter logic [NUM_SRC*PRIO_W-1:0] FIXED_FIELDS = '0
)
(
	// Clock and reset.
	input  wire logic                        ref_clk,
	input  wire logic                        nrst,
	// Write and readback.
	input  wire irq_ctrl_pkg::prio_wr_t      wr,
	input  wire logic [VNUM_W-1:0]           rd_index,
	output logic      [PRIO_W-1:0]           rd_field,
	// All fields in parallel.
	output logic      [NUM_SRC*PRIO_W-1:0]   fields
);
	import irq_ctrl_pkg::*;

	genvar g;

	// Each field resets disabled; fixed sources ignore writes.
	generate
		for (g = 0; g < NUM_SRC; g++)
		begin : g_field
			always_ff @(posedge ref_clk or negedge nrst)
			begin
				if (!nrst)
					fields[g*PRIO_W +: PRIO_W] <= PRIO_DISABLED;
				else if (FIXED_MASK[g])
					fields[g*PRIO_W +: PRIO_W] <=
						FIXED_FIELDS[g*PRIO_W +: PRIO_W];
				else if (wr.en && wr.index == VNUM_W'(g))
					fields[g*PRIO_W +: PRIO_W] <= wr.field;
			end
		end
	endgenerate

	// Readback; an index past the last source reads as zero.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			rd_field <= PRIO_DISABLED;
		else if (rd_index > LAST_SRC)
			rd_field <= PRIO_DISABLED;
		else
			rd_field <= fields[rd_index*PRIO_W +: PRIO_W];
	end

endmodule

// >>> rtl/interrupt_arbiter.sv
`timescale 1ns/100ps

// Behaviour
// - Every source gets a programmable priority level; FIXED_MASK sources hold FIXED_FIELDS instead.
// - Lowest source number wins within a level.
// - Request core and supply service address.
// - Normal vector is base joined with number.
// - Current level encoded in two bits.
// - Fast only on match and level two.
// - Fast vector comes from low/high registers.
// - Fast recognition done before the core.
// - In Wait/Stop signal pending request for wake.
// - Only requests enabled before sleep wake.
// - External inputs level sensitive in Wait/Stop.
// - Stop wake only from CAN or external inputs.
// - Initial address driven after reset.
// - Functional mode after reset.
// - Priority field two bits, resets disabled.
module interrupt_arbiter
	import irq_ctrl_pkg::*;
#(
	parameter logic [NUM_SRC-1:0]        LOW_RANGE    = '0,
	parameter logic [NUM_SRC-1:0]        FIXED_MASK   = '0,
	parameter logic [NUM_SRC*PRIO_W-1:0] FIXED_FIELDS = '0,
	parameter logic [NUM_SRC-1:0]        CAN_MASK     = '0,
	parameter logic [VNUM_W-1:0]         EXT_A_SRC    = 7'h02,
	parameter logic [VNUM_W-1:0]         EXT_B_SRC    = 7'h03
)
(
	// Clock and reset.
	input  wire logic                         ref_clk,
	input  wire logic                         nrst,
	// Interrupt sources, active high, and the two external pins.
	input  wire logic [NUM_SRC-1:0]           irq_src,
	input  wire logic                         ext_irq_a_n,
	input  wire logic                         ext_irq_b_n,
	input  wire logic                         ext_a_edge,
	input  wire logic                         ext_b_edge,
	// Software configuration.
	input  wire irq_ctrl_pkg::prio_wr_t       prio_wr,
	input  wire logic [VNUM_W-1:0]            prio_rd_index,
	input  wire logic [VBASE_W-1:0]           vector_base,
	input  wire irq_ctrl_pkg::fast_cfg_t      fast_cfg_0,
	input  wire irq_ctrl_pkg::fast_cfg_t      fast_cfg_1,
	// Core side.
	input  wire logic [1:0]                   core_status_mask,
	input  wire logic                         irq_ack,
	input  wire logic                         irq_done,
	output irq_ctrl_pkg::core_req_t           core_req,
	output logic [1:0]                        current_level_code,
	output logic                              init_addr_valid,
	output logic [PRIO_W-1:0]                 prio_rd_field,
	// System integration unit side.
	input  wire irq_ctrl_pkg::power_mode_t    power_mode,
	output logic                              wake_req,
	output logic                              functional_mode
);
	import irq_ctrl_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Maps a priority field to a level; the low range shifts 1..3 to 0..2.
	function automatic logic [LEVEL_W-1:0] field_level(
		input logic [PRIO_W-1:0] field,
		input logic              low_range
	);
		logic [LEVEL_W-1:0] lvl;
		lvl = low_range ? LEVEL_W'(field - 2'h1) : field;
		return lvl;
	endfunction

	// Encodes a serviced level as the current level code.
	function automatic logic [1:0] level_code(
		input logic [LEVEL_W-1:0] lvl
	);
		logic [1:0] code;
		case (lvl)
			2'h0:    code = CODE_L0;
			2'h1:    code = CODE_L1;
			default: code = CODE_L23;
		endcase
		return code;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Priority fields.

	logic [NUM_SRC*PRIO_W-1:0] fields;

	priority_level_regs #(
		.FIXED_MASK   (FIXED_MASK),
		.FIXED_FIELDS (FIXED_FIELDS)
	) u_prio (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.wr       (prio_wr),
		.rd_index (prio_rd_index),
		.rd_field (prio_rd_field),
		.fields   (fields)
	);

	////////////////////////////////////////////////////////////////////////
	// External pins and power mode.

	logic       ext_a_prev;
	logic       ext_b_prev;
	logic       ext_a_pend;
	logic       ext_b_pend;
	logic       asleep;
	logic       ack_a;
	logic       ack_b;
	logic [NUM_SRC-1:0] active;

	assign asleep = (power_mode == MODE_WAIT) || (power_mode == MODE_STOP);
	assign ack_a  = irq_ack && core_req.valid && core_req.num == EXT_A_SRC;
	assign ack_b  = irq_ack && core_req.valid && core_req.num == EXT_B_SRC;

	// Previous pin levels for falling-edge detection.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ext_a_prev <= 1'b1;
			ext_b_prev <= 1'b1;
		end
		else
		begin
			ext_a_prev <= ext_irq_a_n;
			ext_b_prev <= ext_irq_b_n;
		end
	end

	// Edge pending flags; a new edge in the acknowledge cycle wins.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ext_a_pend <= 1'b0;
			ext_b_pend <= 1'b0;
		end
		else
		begin
			if (ext_a_prev && !ext_irq_a_n)
				ext_a_pend <= 1'b1;
			else if (ack_a)
				ext_a_pend <= 1'b0;
			if (ext_b_prev && !ext_irq_b_n)
				ext_b_pend <= 1'b1;
			else if (ack_b)
				ext_b_pend <= 1'b0;
		end
	end

	// Active requests; while asleep the pins count by level alone.
	always_comb
	begin
		active = irq_src;
		active[EXT_A_SRC] = (ext_a_edge && !asleep) ? ext_a_pend
			: !ext_irq_a_n;
		active[EXT_B_SRC] = (ext_b_edge && !asleep) ? ext_b_pend
			: !ext_irq_b_n;
	end

	////////////////////////////////////////////////////////////////////////
	// Arbitration.

	logic [3:0]             lvl_any;
	logic [VNUM_W-1:0]      lvl_win [4];
	logic [LEVEL_W-1:0]     best_lvl;
	logic [VNUM_W-1:0]      best_num;
	logic                   best_any;
	logic [1:0]             threshold;
	logic                   admitted;
	logic                   next_fast;
	logic [ADDR_W-1:0]      next_addr;
	logic [NUM_SRC-1:0]     enabled;

	// Scanning downward leaves the lowest number as each level's winner.
	always_comb
	begin
		logic [LEVEL_W-1:0] lvl;
		lvl     = 2'h0;
		lvl_any = 4'h0;
		enabled = '0;
		for (int l = 0; l < 4; l++)
			lvl_win[l] = VNUM_RESET;
		for (int s = NUM_SRC - 1; s >= 0; s--)
		begin
			enabled[s] = fields[s*PRIO_W +: PRIO_W] != PRIO_DISABLED;
			lvl = field_level(fields[s*PRIO_W +: PRIO_W], LOW_RANGE[s]);
			if (active[s] && enabled[s])
			begin
				lvl_any[lvl] = 1'b1;
				lvl_win[lvl] = VNUM_W'(s);
			end
		end
	end

	// The highest occupied level is offered to the core.
	always_comb
	begin
		best_any = 1'b0;
		best_lvl = 2'h0;
		best_num = VNUM_RESET;
		for (int l = 0; l < 4; l++)
		begin
			if (lvl_any[l])
			begin
				best_any = 1'b1;
				best_lvl = LEVEL_W'(l);
				best_num = lvl_win[l];
			end
		end
	end

	// Nesting: the stricter of the core mask and the current level wins,
	// and each code's value equals the least level that it admits.
	assign threshold = (core_status_mask > current_level_code)
		? core_status_mask : current_level_code;
	assign admitted  = best_any && (best_lvl >= threshold);

	// Fast matching on the winner; slot 0 takes precedence on a tie.
	always_comb
	begin
		next_fast = 1'b0;
		next_addr = {vector_base, best_num};
		if (best_lvl == FAST_LEVEL)
		begin
			if (best_num == fast_cfg_0.match)
			begin
				next_fast = 1'b1;
				next_addr = {fast_cfg_0.high, fast_cfg_0.low};
			end
			else if (best_num == fast_cfg_1.match)
			begin
				next_fast = 1'b1;
				next_addr = {fast_cfg_1.high, fast_cfg_1.low};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core outputs.

	// The request is registered with its address, so the fast address is
	// already in place when the core vectors; the reset value is the
	// initial address.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			core_req.valid <= 1'b0;
			core_req.fast  <= 1'b0;
			core_req.level <= 2'h0;
			core_req.num   <= VNUM_RESET;
			core_req.addr  <= INIT_ADDR;
		end
		else if (admitted)
		begin
			core_req.valid <= 1'b1;
			core_req.fast  <= next_fast;
			core_req.level <= best_lvl;
			core_req.num   <= best_num;
			core_req.addr  <= next_addr;
		end
		else
			core_req.valid <= 1'b0;
	end

	// Marks the cycle after reset in which the initial address is shown.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			init_addr_valid <= 1'b1;
		else
			init_addr_valid <= 1'b0;
	end

	// One level is held; the core restores outer levels from its own mask,
	// which keeps this small at the cost of no nesting stack here.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			current_level_code <= CODE_NONE;
		else if (irq_ack && core_req.valid)
			current_level_code <= level_code(core_req.level);
		else if (irq_done)
			current_level_code <= CODE_NONE;
	end

	////////////////////////////////////////////////////////////////////////
	// Wake-up for Wait and Stop.

	logic               asleep_prev;
	logic [NUM_SRC-1:0] enabled_snap;
	logic [NUM_SRC-1:0] stop_ok;
	logic               next_wake;

	// Sources that can run without clocks in Stop.
	always_comb
	begin
		stop_ok = CAN_MASK;
		stop_ok[EXT_A_SRC] = 1'b1;
		stop_ok[EXT_B_SRC] = 1'b1;
	end

	// Enables are frozen on entry, so late enables never wake the core.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			asleep_prev  <= 1'b0;
			enabled_snap <= '0;
		end
		else
		begin
			asleep_prev <= asleep;
			if (!asleep)
				enabled_snap <= enabled;
		end
	end

	always_comb
	begin
		case (power_mode)
			MODE_WAIT: next_wake = |(active & enabled_snap);
			MODE_STOP: next_wake = |(active & enabled_snap & stop_ok);
			default:   next_wake = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			wake_req <= 1'b0;
		else
			wake_req <= next_wake && asleep_prev;
	end

	// Functional mode from reset; low while the system sleeps.
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			functional_mode <= 1'b1;
		else
			functional_mode <= !asleep;
	end

endmodule

// >>> verification/irq_ctrl_properties.sv
`timescale 1ns/100ps

// Port checker for the arbiter; every answer is tied to its cause.
module irq_ctrl_properties
(
	// Clock and reset.
	input wire logic                         ref_clk,
	input wire logic                         nrst,
	// Configuration and core side.
	input wire logic [irq_ctrl_pkg::VBASE_W-1:0] vector_base,
	input wire irq_ctrl_pkg::fast_cfg_t      fast_cfg_0,
	input wire irq_ctrl_pkg::fast_cfg_t      fast_cfg_1,
	input wire logic [1:0]                   core_status_mask,
	input wire logic                         irq_ack,
	input wire logic                         irq_done,
	input wire irq_ctrl_pkg::core_req_t      core_req,
	input wire logic [1:0]                   current_level_code,
	input wire logic                         init_addr_valid,
	// System integration unit side.
	input wire irq_ctrl_pkg::power_mode_t    power_mode,
	input wire logic                         wake_req,
	input wire logic                         functional_mode
);
	import irq_ctrl_pkg::*;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	////////////////////////////////////////////////////////////////////////
	// Reset address and mode.
	a_init_addr_drive: assert property (
		init_addr_valid |-> core_req.addr == INIT_ADDR && !core_req.valid)
		else $error("reset address not on the bus");
	a_init_one_shot: assert property (
		init_addr_valid |=> !init_addr_valid)
		else $error("reset address flag held too long");
	a_mode_follows: assert property (
		1'b1 |=> functional_mode == ($past(power_mode) == MODE_RUN))
		else $error("functional flag wrong for the power mode");

	////////////////////////////////////////////////////////////////////////
	// Nesting: the level code follows acks and returns.
	a_level_code_ack: assert property (
		irq_ack && core_req.valid |=> current_level_code ==
		(($past(core_req.level) == 2'h0) ? CODE_L0 :
		($past(core_req.level) == 2'h1) ? CODE_L1 : CODE_L23))
		else $error("level code not set by ack");
	a_done_clears: assert property (
		irq_done && !(irq_ack && core_req.valid) |=>
		current_level_code == CODE_NONE)
		else $error("level code not cleared on return");
	a_admit_level: assert property (
		core_req.valid |-> core_req.level >= $past(core_status_mask)
		&& core_req.level >= $past(current_level_code))
		else $error("request below the admitted level");

	////////////////////////////////////////////////////////////////////////
	// Vector address forming.
	a_normal_addr: assert property (
		core_req.valid && !core_req.fast |->
		core_req.addr == {$past(vector_base), core_req.num})
		else $error("normal vector address wrong");
	a_fast_addr: assert property (
		core_req.valid && core_req.fast |-> core_req.level == FAST_LEVEL
		&& core_req.addr == ((core_req.num == $past(fast_cfg_0.match)) ?
		$past(fast_cfg_0[ADDR_W-1:0]) : $past(fast_cfg_1[ADDR_W-1:0])))
		else $error("fast vector address wrong");
	a_fast_flag: assert property (
		core_req.valid && core_req.level == FAST_LEVEL &&
		(core_req.num == $past(fast_cfg_0.match) ||
		core_req.num == $past(fast_cfg_1.match)) |-> core_req.fast)
		else $error("fast request not flagged");

	////////////////////////////////////////////////////////////////////////
	// Wake-up only after two sleeping cycles.
	a_wake_asleep: assert property (
		wake_req |-> $past(power_mode) != MODE_RUN &&
		$past(power_mode, 2) != MODE_RUN)
		else $error("wake request while running");
endmodule

// >>> verification/core_model.sv
`timescale 1ns/100ps

// Behavioural core: takes requests at random and returns now and then,
// so that nesting and the mask get exercised.
module core_model
(
	// Clock.
	input  wire logic                   ref_clk,
	// Bench control.
	input  wire logic                   enable,
	// Request and the core's answers.
	input  wire irq_ctrl_pkg::core_req_t core_req,
	output logic [1:0]                  core_status_mask,
	output logic                        irq_ack,
	output logic                        irq_done
);
	import irq_ctrl_pkg::*;

	int          seed = 32'h5a17;
	logic [31:0] r;
	logic        in_fast;

	// Stand-in encoding of the subroutine jump; the value is arbitrary.
	localparam logic [7:0] subroutine_jump_opcode = 8'h5d;

	// Answers change just after the edge and hold for a whole cycle.
	initial
	begin
		core_status_mask = 2'h0;
		irq_ack = 1'b0;
		irq_done = 1'b0;
		in_fast = 1'b0;
		forever
		begin
			@(posedge ref_clk);
			#1;
			r = $random(seed);
			if (r[7:4] == 4'h0)
				core_status_mask = r[9:8];
			irq_ack = enable && core_req.valid && r[0];
			irq_done = enable && !irq_ack
				&& (in_fast ? r[2:1] == 2'h0 : r[3:1] == 3'h0);
			// The fetched handler word stands as r[15:8]; a subroutine
			// jump there keeps the service normal, so fast ones end sooner.
			if (irq_ack)
				in_fast = core_req.fast && r[15:8] != subroutine_jump_opcode;
			else if (irq_done)
				in_fast = 1'b0;
		end
	end
endmodule

// >>> verification/interrupt_arbiter_bench.sv
`timescale 1ns/100ps

// Reference model runs beside the arbiter and is compared every cycle; the request only while run_chk is set.
module interrupt_arbiter_bench;
	import irq_ctrl_pkg::*;

	// Sources 40 and up use the low range; source 20 may wake from stop.
	localparam logic [NUM_SRC-1:0] LOW = {{46{1'b1}}, 40'h0};
	localparam logic [NUM_SRC-1:0] CAN = 86'h10_0000;

	logic               ref_clk, nrst, ext_irq_a_n, ext_irq_b_n;
	logic               ext_a_edge, ext_b_edge, run_chk, slp, exp_wake;
	logic               irq_ack, irq_done, init_addr_valid;
	logic               wake_req, functional_mode;
	logic [NUM_SRC-1:0] irq_src, act, snap, wake_mask;
	logic [VBASE_W-1:0] vector_base;
	logic [VNUM_W-1:0]  prio_rd_index;
	logic [1:0]         core_status_mask, current_level_code;
	logic [1:0]         prio_rd_field, exp_rd;
	logic [1:0]         pend, prev, exp_misc;
	fast_cfg_t          fast_cfg_0, fast_cfg_1;
	prio_wr_t           prio_wr;
	power_mode_t        power_mode;
	core_req_t          core_req, exp_req, next_req;
	int                 fld [NUM_SRC];
	int                 code, num_errors, cmp_count;
	int                 seed = 32'hc4ee;

	interrupt_arbiter #(.LOW_RANGE(LOW), .CAN_MASK(CAN)) uut
	(
		.ref_clk, .nrst, .irq_src, .ext_irq_a_n, .ext_irq_b_n, .ext_a_edge,
		.ext_b_edge, .prio_wr, .prio_rd_index, .vector_base,
		.fast_cfg_0, .fast_cfg_1, .core_status_mask, .irq_ack, .irq_done,
		.core_req, .current_level_code, .init_addr_valid, .prio_rd_field,
		.power_mode, .wake_req, .functional_mode
	);

	core_model core
	(
		.ref_clk, .enable(run_chk), .core_req, .core_status_mask,
		.irq_ack, .irq_done
	);

	initial
	begin
		ref_clk = 1'b0;
		forever
			#4 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////
	// Highest admitted level wins, then the lowest source number.
	function automatic core_req_t arb(logic [NUM_SRC-1:0] a);
		core_req_t r;
		int        l;
		r = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			l = fld[i] - int'(LOW[i]);
			if (a[i] && fld[i] != 0 && l >= core_status_mask && l >= code
				&& (!r.valid || l >= r.level))
				r = '{1'b1, 1'b0, 2'(l), 7'(i), 21'h0};
		end
		r.fast = r.valid && r.level == FAST_LEVEL &&
			(r.num == fast_cfg_0.match || r.num == fast_cfg_1.match);
		r.addr = !r.fast ? {vector_base, r.num} : (r.num == fast_cfg_0.match)
			? fast_cfg_0[ADDR_W-1:0] : fast_cfg_1[ADDR_W-1:0];
		return r;
	endfunction

	// The model samples on the same edge as the arbiter; inputs are
	// stable there because every driver moves just after the edge.
	always @(posedge ref_clk or negedge nrst)
		if (!nrst)
		begin
			fld = '{default: 0};
			code = 0;
			exp_req = '0;
			exp_rd = 2'h0;
			exp_wake = 1'b0;
			snap = '0;
			slp = 1'b0;
			pend = 2'b00;
			prev = 2'b11;
			exp_misc = 2'b11;
		end
		else
		begin
			act = irq_src;
			// Edge-mode pins count by their pending flag only while running.
			act[2] = (ext_a_edge && power_mode == MODE_RUN) ? pend[0]
				: !ext_irq_a_n;
			act[3] = (ext_b_edge && power_mode == MODE_RUN) ? pend[1]
				: !ext_irq_b_n;
			wake_mask = (power_mode == MODE_STOP) ? (CAN | 86'hc) : '1;
			exp_wake = slp && power_mode != MODE_RUN &&
				|(act & snap & wake_mask);
			exp_rd = (prio_rd_index < NUM_SRC) ? 2'(fld[prio_rd_index]) : 2'h0;
			next_req = arb(act);
			if (irq_ack && exp_req.valid)
				code = (exp_req.level == 2'h0) ? 1 : (exp_req.level == 2'h1) ? 2 : 3;
			else if (irq_done)
				code = 0;
			for (int i = 0; i < NUM_SRC; i++)
				if (power_mode == MODE_RUN)
					snap[i] = fld[i] != 0;
			if (prio_wr.en && prio_wr.index < NUM_SRC)
				fld[prio_wr.index] = prio_wr.field;
			// A new falling edge wins over the acknowledge of that pin.
			for (int k = 0; k < 2; k++)
				if (prev[k] && !(k ? ext_irq_b_n : ext_irq_a_n))
					pend[k] = 1'b1;
				else if (irq_ack && exp_req.valid
					&& exp_req.num == 7'(k + 2))
					pend[k] = 1'b0;
			prev = {ext_irq_b_n, ext_irq_a_n};
			exp_misc = {1'b0, power_mode == MODE_RUN};
			slp = power_mode != MODE_RUN;
			exp_req = next_req;
		end

	////////////////////////////////////////////////////////////////////////
	// Compares, made at the falling edge where outputs have settled.
	task automatic chk_req(core_req_t g, core_req_t e);
		cmp_count++;
		if (e.valid ? g !== e : g.valid !== 1'b0)
		begin
			num_errors++;
			$display("Error %0t: request %h, expected %h", $time, g, e);
		end
	endtask

	task automatic chk_bits(logic [1:0] g, logic [1:0] e);
		cmp_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error %0t: value %b, expected %b", $time, g, e);
		end
	endtask

	always @(negedge ref_clk)
		if (nrst)
		begin
			if (run_chk)
				chk_req(core_req, exp_req);
			chk_bits(current_level_code, 2'(code));
			chk_bits(prio_rd_field, exp_rd);
			chk_bits({1'b0, wake_req}, {1'b0, exp_wake});
			chk_bits({init_addr_valid, functional_mode}, exp_misc);
		end

	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask

	task automatic wr(int i, int f);
		prio_wr = '{1'b1, 7'(i), 2'(f)};
		tick();
		prio_wr.en = 1'b0;
		tick();
	endtask

	task automatic pulse(int i);
		irq_src[i] = 1'b1;
		repeat (4) tick();
		irq_src[i] = 1'b0;
		repeat (2) tick();
	endtask

	// Sparse random sources and pins, writes and readback each cycle.
	task automatic rnd(int n);
		logic [95:0] a, b, c, x;
		repeat (n)
		begin
			a = {$random(seed), $random(seed), $random(seed)};
			b = {$random(seed), $random(seed), $random(seed)};
			c = {$random(seed), $random(seed), $random(seed)};
			x = a & b & c;
			irq_src = x[85:0];
			{ext_irq_a_n, ext_irq_b_n} = ~x[87:86];
			prio_wr = '{a[88] & b[88], c[94:88], b[95:94]};
			prio_rd_index = a[94:88];
			tick();
		end
	endtask

	task automatic final_report();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		#60000;
		num_errors++;
		final_report();
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		nrst = 1'b0;
		irq_src = '0;
		{ext_irq_a_n, ext_irq_b_n, ext_a_edge, ext_b_edge, run_chk} = 5'b11000;
		prio_wr = '0;
		prio_rd_index = '0;
		power_mode = MODE_RUN;
		num_errors = 0;
		cmp_count = 0;
		vector_base = 14'($random(seed));
		// Fast handlers at random addresses on sources 5 and 44.
		fast_cfg_0 = '{7'h05, 5'($random(seed)), 16'($random(seed))};
		fast_cfg_1 = '{7'h2c, 5'($random(seed)), 16'($random(seed))};
		repeat (4) tick();
		nrst = 1'b1;
		run_chk = 1'b1;
		rnd(1500);
		// Both slots on one number: slot 0 must win.
		fast_cfg_0.match = 7'h09;
		fast_cfg_1.match = 7'h09;
		// Both pins in falling-edge mode while the core runs.
		{ext_a_edge, ext_b_edge} = 2'b11;
		rnd(1500);
		// Sleep: only sources enabled beforehand may wake.
		{run_chk, irq_src, prio_wr, ext_a_edge, ext_b_edge} = '0;
		{ext_irq_a_n, ext_irq_b_n} = 2'b11;
		wr(10, 1);
		wr(20, 1);
		wr(2, 2);
		tick();
		power_mode = MODE_WAIT;
		pulse(10);
		wr(30, 1);
		pulse(30);
		power_mode = MODE_STOP;
		pulse(10);
		pulse(20);
		ext_a_edge = 1'b1;
		pulse(2);
		ext_irq_a_n = 1'b0;
		repeat (4) tick();
		{ext_irq_a_n, ext_a_edge} = 2'b10;
		power_mode = MODE_RUN;
		tick();
		// A second reset in mid-run, then more traffic.
		nrst = 1'b0;
		repeat (2) tick();
		nrst = 1'b1;
		run_chk = 1'b1;
		rnd(200);
		final_report();
	end
endmodule

bind interrupt_arbiter irq_ctrl_properties chk
(
	.ref_clk, .nrst, .vector_base, .fast_cfg_0, .fast_cfg_1,
	.core_status_mask, .irq_ack, .irq_done, .core_req,
	.current_level_code, .init_addr_valid, .power_mode, .wake_req,
	.functional_mode
);
